// file: common/wake_cdr_pkg.sv
// package: register map, field layout and constants of the wake clock-recovery registers
package wake_cdr_pkg;
    // ************************************************************
    // serial frame layout
    // ************************************************************
    localparam int FRAME_BITS = 16;
    localparam int MODE_BIT = 7;
    localparam int DATA_LSB = 8;
    localparam logic [4:0] COUNT_FULL = 5'h10;
    localparam logic [4:0] COUNT_OVER = 5'h11;
    localparam logic [4:0] COUNT_LAST = 5'h0f;
    typedef enum logic {ACCESS_READ = 1'b0, ACCESS_ACT = 1'b1} access_mode_type;

    // ************************************************************
    // register addresses, reset values and masks
    // ************************************************************
    localparam logic [6:0] ADDR_CONTROL_ONE = 7'h3c;
    localparam logic [6:0] ADDR_CLOCK_SELECT = 7'h3d;
    localparam logic [6:0] ADDR_UPPER_LIMIT = 7'h3e;
    localparam logic [6:0] ADDR_LOWER_LIMIT = 7'h3f;
    localparam logic [6:0] ADDR_STATUS = 7'h70;
    localparam logic [7:0] CONTROL_ONE_RESET = 8'h04;
    localparam logic [1:0] CLOCK_SELECT_RESET = 2'h0;
    localparam logic [7:0] UPPER_LIMIT_RESET = 8'ha8;
    localparam logic [7:0] LOWER_LIMIT_RESET = 8'h98;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] RESP_RESET = 16'h0000;
    localparam logic [7:0] CONTROL_ONE_MASK = 8'h0d;
    localparam logic [7:0] STATUS_CLEAR_MASK = 8'h23;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ENABLE_POS = 0;
    localparam int FILTER_LSB = 2;
    localparam int STAT_UPPER_POS = 0;
    localparam int STAT_LOWER_POS = 1;
    localparam int STAT_WDOG_LSB = 2;
    localparam int STAT_ACTIVE_POS = 4;
    localparam int STAT_FRAME_POS = 5;

    // ************************************************************
    // filter, clock and clamp constants
    // ************************************************************
    localparam logic [1:0] FILTER_SHORT = 2'h0;
    localparam logic [1:0] FILTER_MID = 2'h1;
    localparam logic [1:0] FILTER_LONG = 2'h2;
    localparam logic [5:0] TC_SHORT = 6'h08;
    localparam logic [5:0] TC_MID = 6'h10;
    localparam logic [5:0] TC_LONG = 6'h20;
    localparam logic [3:0] GAP_LONG_MIN = 4'h2;
    localparam logic [3:0] GAP_LONG_MAX = 4'h3;
    localparam logic [3:0] GAP_MID_MIN = 4'h4;
    localparam logic [3:0] GAP_MID_MAX = 4'h8;
    localparam logic [3:0] GAP_SHORT_MIN = 4'h9;
    localparam logic [3:0] GAP_SHORT_MAX = 4'ha;
    localparam logic [6:0] MHZ_80 = 7'h50;
    localparam logic [6:0] MHZ_40 = 7'h28;
    localparam logic [6:0] MHZ_20 = 7'h14;
    localparam logic [6:0] MHZ_10 = 7'h0a;
    // 5 % band: compare measured*20 against setting*21 and setting*19
    localparam logic [4:0] CLAMP_BASE = 5'h14;
    localparam logic [4:0] CLAMP_UP = 5'h15;
    localparam logic [4:0] CLAMP_DOWN = 5'h13;
endpackage

// file: common/spi_link_if.sv
// interface: captured frame and answer word between link shifter and register core
`timescale 1ns/1ns
interface spi_link_if;
    logic [15:0] word;
    logic [4:0] bit_count;
    logic [15:0] resp;
    modport link (output word, output bit_count, input resp);
    modport core (input word, input bit_count, output resp);
endinterface

// file: core/spi_link_shifter.sv
// link-side shifter: takes the serial frame on the link clock and shifts the answer out
`timescale 1ns/1ns
module spi_link_shifter
(
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    spi_link_if.link link_bus
);
    import wake_cdr_pkg::*;

    typedef struct packed
    {
        logic [4:0] count;
        logic [15:0] shift;
    } link_state_type;

    link_state_type cur;
    link_state_type next_link;
    logic first_edge;
    logic tx;
    logic next_tx;
    logic [3:0] bit_index;

    // lsb first; count saturates one above a full frame so long frames are caught
    always_comb
    begin
        next_link = cur;
        bit_index = first_edge ? 4'h0 : cur.count[3:0];
        next_link.shift = {spi_mosi, cur.shift[FRAME_BITS-1:1]};
        if (first_edge)
            next_link.count = 5'h01;
        else if (cur.count != COUNT_OVER)
            next_link.count = cur.count + 5'h01;
        next_tx = 1'b0;
        if (first_edge || cur.count < COUNT_LAST)
            next_tx = link_bus.resp[bit_index + 4'h1];
    end

    // the link clock stops between frames, so this state has no reset of its own
    always_ff @(posedge spi_clk)
    begin
        cur <= next_link;
    end

    // deselect ends the frame: answer bit 0 is always zero, so tx parks at zero
    always_ff @(posedge spi_clk or posedge spi_cs_n)
    begin
        if (spi_cs_n)
        begin
            first_edge <= 1'b1;
            tx <= 1'b0;
        end
        else
        begin
            first_edge <= 1'b0;
            tx <= next_tx;
        end
    end

    assign spi_miso = tx;
    assign link_bus.word = cur.shift;
    assign link_bus.bit_count = cur.count;
endmodule

// file: core/wake_cdr_config_regs.sv
// register core: wake clock-recovery configuration, status read/clear and bit-time clamp
//
// Function
// - filter code 00/01/10 gives 8/16/32
// - code 11 adapts constant to edge spacing
// - clock select picks 80/40/20/10 MHz
// - above setting plus 5% clamps to upper
// - below setting minus 5% clamps to lower
// - frame: 7-bit address, mode bit, data byte
// - data bits 0..7 in frame bits 8..15
// - mode 0 reads, status left unchanged
// - mode 1 clears clearable status bits bytewise
// - read-only and reserved bits ignore clears
// - only host clears status, watchdog and active bits excepted
// - reserved control bits read as zero
// - clock select resets zero, survives restart
// - limits reset a8/98, survive restart
`timescale 1ns/1ns
module wake_cdr_config_regs
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SPI_CLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_MOSI,
    output logic SPI_MISO,
    output logic SPI_MISO_OE_N,
    input wire logic RESTART,
    input wire logic [1:0] WATCHDOG_FAILURE_BITS,
    input wire logic EDGE_VALID,
    input wire logic [3:0] EDGE_SPACING,
    input wire logic MEAS_VALID,
    input wire logic [7:0] MEAS_LEN,
    input wire logic [7:0] BIT_LENGTH_SETTING,
    output logic CLOCK_RECOVERY_ENABLE,
    output logic [5:0] FILTER_TIME_CONSTANT,
    output logic [1:0] RECOVERY_CLOCK_SEL,
    output logic [6:0] RECOVERY_CLOCK_MHZ,
    output logic [7:0] CLAMPED_LEN,
    output logic CLAMPED_VALID,
    output logic [15:0] LAST_ANSWER,
    output logic [7:0] STATUS_FLAGS
);
    import wake_cdr_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed
    {
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic miso_oe_n;
        logic [7:0] control_one;
        logic [1:0] clock_sel;
        logic [7:0] upper_limit;
        logic [7:0] lower_limit;
        logic [7:0] status;
        logic [15:0] resp;
        logic [5:0] filter_const;
        logic [6:0] clock_mhz;
        logic [7:0] clamped_len;
        logic clamped_valid;
    } core_state_type;

    localparam core_state_type CORE_RESET = '{
        cs_meta: 1'b1,
        cs_sync: 1'b1,
        cs_prev: 1'b1,
        miso_oe_n: 1'b1,
        control_one: CONTROL_ONE_RESET,
        clock_sel: CLOCK_SELECT_RESET,
        upper_limit: UPPER_LIMIT_RESET,
        lower_limit: LOWER_LIMIT_RESET,
        status: STATUS_RESET,
        resp: RESP_RESET,
        filter_const: TC_MID,
        clock_mhz: MHZ_80,
        clamped_len: 8'h00,
        clamped_valid: 1'b0
    };

    core_state_type cur;
    core_state_type next_core;
    spi_link_if link_bus ();

    logic frame_end;
    logic frame_good;
    logic [6:0] frame_addr;
    access_mode_type frame_mode;
    logic [7:0] frame_data;
    logic above_band;
    logic below_band;
    logic hit_upper;
    logic hit_lower;
    logic [7:0] status_set;
    logic [7:0] status_clear;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [12:0] scale(input logic [7:0] value, input logic [4:0] factor);
        scale = 13'(value) * 13'(factor);
    endfunction

    function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo,
                                      input logic [3:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic [6:0] clock_mhz(input logic [1:0] sel);
        case (sel)
            2'h0: clock_mhz = MHZ_80;
            2'h1: clock_mhz = MHZ_40;
            2'h2: clock_mhz = MHZ_20;
            default: clock_mhz = MHZ_10;
        endcase
    endfunction

    function automatic logic [7:0] read_value(input logic [6:0] addr, input core_state_type s);
        case (addr)
            ADDR_CONTROL_ONE: read_value = s.control_one & CONTROL_ONE_MASK;
            ADDR_CLOCK_SELECT: read_value = {6'h00, s.clock_sel};
            ADDR_UPPER_LIMIT: read_value = s.upper_limit;
            ADDR_LOWER_LIMIT: read_value = s.lower_limit;
            ADDR_STATUS: read_value = s.status;
            default: read_value = 8'h00;
        endcase
    endfunction

    // ************************************************************
    // link side
    // ************************************************************
    spi_link_shifter link_shifter
    (
        .spi_clk(SPI_CLK),
        .spi_cs_n(SPI_CS_N),
        .spi_mosi(SPI_MOSI),
        .spi_miso(SPI_MISO),
        .link_bus(link_bus)
    );

    // the frame word is still on the link side when deselect is seen here: the link
    // clock has stopped, so the synchronised deselect edge qualifies the word
    assign frame_end = cur.cs_sync & ~cur.cs_prev;
    assign frame_good = (link_bus.bit_count == COUNT_FULL);
    assign frame_addr = link_bus.word[6:0];
    assign frame_mode = access_mode_type'(link_bus.word[MODE_BIT]);
    assign frame_data = link_bus.word[DATA_LSB +: 8];
    assign link_bus.resp = cur.resp;

    // ************************************************************
    // bit-time clamp
    // ************************************************************
    assign above_band = scale(MEAS_LEN, CLAMP_BASE) > scale(BIT_LENGTH_SETTING, CLAMP_UP);
    assign below_band = scale(MEAS_LEN, CLAMP_BASE) < scale(BIT_LENGTH_SETTING, CLAMP_DOWN);
    assign hit_upper = MEAS_VALID & cur.control_one[ENABLE_POS] & above_band;
    assign hit_lower = MEAS_VALID & cur.control_one[ENABLE_POS] & below_band;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_core = cur;
        status_set = 8'h00;
        status_clear = 8'h00;
        next_core.cs_meta = SPI_CS_N;
        next_core.cs_sync = cur.cs_meta;
        next_core.cs_prev = cur.cs_sync;
        next_core.miso_oe_n = cur.cs_sync;

        if (frame_end)
        begin
            if (frame_good)
            begin
                // answer shows the value before this frame acts on it
                next_core.resp = {read_value(frame_addr, cur), frame_addr, 1'b0};
                // a read frame only answers; nothing below runs for it
                if (frame_mode == ACCESS_ACT)
                begin
                    case (frame_addr)
                        ADDR_CONTROL_ONE: next_core.control_one = frame_data & CONTROL_ONE_MASK;
                        ADDR_CLOCK_SELECT: next_core.clock_sel = frame_data[1:0];
                        ADDR_UPPER_LIMIT: next_core.upper_limit = frame_data;
                        ADDR_LOWER_LIMIT: next_core.lower_limit = frame_data;
                        ADDR_STATUS: status_clear = STATUS_CLEAR_MASK;
                        default: ;
                    endcase
                end
            end
            else
            begin
                status_set[STAT_FRAME_POS] = 1'b1;
            end
        end

        // restart drops the enable only; clock select and limits are kept
        if (RESTART)
            next_core.control_one[ENABLE_POS] = 1'b0;

        status_set[STAT_UPPER_POS] = hit_upper;
        status_set[STAT_LOWER_POS] = hit_lower;
        // an event in the clearing cycle survives: set is applied after clear
        next_core.status = ((cur.status & ~status_clear) | status_set) & STATUS_CLEAR_MASK;
        next_core.status[STAT_WDOG_LSB +: 2] = WATCHDOG_FAILURE_BITS;
        next_core.status[STAT_ACTIVE_POS] = cur.control_one[ENABLE_POS];

        case (cur.control_one[FILTER_LSB +: 2])
            FILTER_SHORT: next_core.filter_const = TC_SHORT;
            FILTER_MID: next_core.filter_const = TC_MID;
            FILTER_LONG: next_core.filter_const = TC_LONG;
            default:
            begin
                if (EDGE_VALID && in_range(EDGE_SPACING, GAP_LONG_MIN, GAP_LONG_MAX))
                    next_core.filter_const = TC_LONG;
                else if (EDGE_VALID && in_range(EDGE_SPACING, GAP_MID_MIN, GAP_MID_MAX))
                    next_core.filter_const = TC_MID;
                else if (EDGE_VALID && in_range(EDGE_SPACING, GAP_SHORT_MIN, GAP_SHORT_MAX))
                    next_core.filter_const = TC_SHORT;
            end
        endcase

        next_core.clock_mhz = clock_mhz(cur.clock_sel);
        next_core.clamped_valid = MEAS_VALID & cur.control_one[ENABLE_POS];
        if (hit_upper)
            next_core.clamped_len = cur.upper_limit;
        else if (hit_lower)
            next_core.clamped_len = cur.lower_limit;
        else if (MEAS_VALID)
            next_core.clamped_len = MEAS_LEN;
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
            cur <= CORE_RESET;
        else
            cur <= next_core;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign SPI_MISO_OE_N = cur.miso_oe_n;
    assign CLOCK_RECOVERY_ENABLE = cur.control_one[ENABLE_POS];
    assign FILTER_TIME_CONSTANT = cur.filter_const;
    assign RECOVERY_CLOCK_SEL = cur.clock_sel;
    assign RECOVERY_CLOCK_MHZ = cur.clock_mhz;
    assign CLAMPED_LEN = cur.clamped_len;
    assign CLAMPED_VALID = cur.clamped_valid;
    assign LAST_ANSWER = cur.resp;
    assign STATUS_FLAGS = cur.status;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking chk_clk @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    sequence seq_frame(logic [6:0] addr, access_mode_type mode);
        frame_end && frame_good && frame_addr == addr && frame_mode == mode;
    endsequence

    sequence seq_quiet_events;
        !hit_upper && !hit_lower;
    endsequence

    a_filter_fixed: assert property
        (cur.control_one[3:2] != 2'h3 |=> FILTER_TIME_CONSTANT ==
            ($past(cur.control_one[3:2]) == 2'h0 ? 6'h08 :
             $past(cur.control_one[3:2]) == 2'h1 ? 6'h10 : 6'h20))
        else $error("fixed filter constant wrong");

    a_filter_adapt: assert property
        (cur.control_one[3:2] == 2'h3 && EDGE_VALID && EDGE_SPACING inside {[4'h2:4'h3]}
            |=> FILTER_TIME_CONSTANT == 6'h20)
        else $error("adaptive filter constant wrong");

    a_enable_write: assert property
        (seq_frame(ADDR_CONTROL_ONE, ACCESS_ACT) ##0 !RESTART
            |=> CLOCK_RECOVERY_ENABLE == $past(frame_data[0]))
        else $error("enable bit not taken");

    a_clock_mhz: assert property
        (seq_frame(ADDR_CLOCK_SELECT, ACCESS_ACT)
            |=> ##1 RECOVERY_CLOCK_MHZ == clock_mhz($past(frame_data[1:0], 2)))
        else $error("recovery clock value wrong");

    a_clamp_upper: assert property
        (MEAS_VALID && CLOCK_RECOVERY_ENABLE && MEAS_LEN * 20 > BIT_LENGTH_SETTING * 21
            |=> CLAMPED_VALID && CLAMPED_LEN == $past(cur.upper_limit) && STATUS_FLAGS[0])
        else $error("upper clamp missing");

    a_clamp_lower: assert property
        (MEAS_VALID && CLOCK_RECOVERY_ENABLE && MEAS_LEN * 20 < BIT_LENGTH_SETTING * 19
            |=> CLAMPED_VALID && CLAMPED_LEN == $past(cur.lower_limit) && STATUS_FLAGS[1])
        else $error("lower clamp missing");

    a_answer_echo: assert property
        (frame_end && frame_good |=> LAST_ANSWER[7:1] == $past(frame_addr) && !LAST_ANSWER[0])
        else $error("answer address echo wrong");

    a_read_keeps: assert property
        (seq_frame(ADDR_STATUS, ACCESS_READ) ##0 seq_quiet_events
            |=> (STATUS_FLAGS & 8'h23) == ($past(STATUS_FLAGS) & 8'h23))
        else $error("status read changed flags");

    a_clear_byte: assert property
        (seq_frame(ADDR_STATUS, ACCESS_ACT) ##0 seq_quiet_events
            |=> (STATUS_FLAGS & 8'h23) == 8'h00
                && STATUS_FLAGS[3:2] == $past(WATCHDOG_FAILURE_BITS))
        else $error("status clear wrong");

    a_no_self_clear: assert property
        (!(frame_end && frame_good && frame_mode == ACCESS_ACT && frame_addr == ADDR_STATUS)
            |=> (STATUS_FLAGS & $past(STATUS_FLAGS) & 8'h23) == ($past(STATUS_FLAGS) & 8'h23))
        else $error("status flag dropped without clear");

    a_reserved_zero: assert property
        (seq_frame(ADDR_CONTROL_ONE, ACCESS_ACT) ##0 (frame_data[7:4] != 4'h0)
            |=> (cur.control_one & 8'hf2) == 8'h00)
        else $error("reserved control bits set");

    a_restart_keep: assert property
        (RESTART && !frame_end |=> !CLOCK_RECOVERY_ENABLE && $stable(RECOVERY_CLOCK_SEL)
            && $stable(cur.upper_limit) && $stable(cur.lower_limit))
        else $error("restart altered kept fields");
endmodule

// file: testbench/spi_host_model.sv
// serial host model: sixteen-bit frames, lsb first, answer captured while sending
`timescale 1ns/1ns
module spi_host_model
(
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial
    begin
        sclk = 1'b0;
        // one early select edge, so the link side's select-driven reset surely runs
        cs_n = 1'b0;
        mosi = 1'b0;
        #1;
        cs_n = 1'b1;
    end

    // clock runs only inside a frame; released data goes inverted so a stale bit never passes
    task automatic frame(input logic [15:0] word, output logic [15:0] got);
        cs_n = 1'b0;
        #64;
        for (int i = 0; i < 16; i++)
        begin
            mosi = word[i];
            #32;
            got[i] = miso;
            sclk = 1'b1;
            #32;
            sclk = 1'b0;
        end
        #32;
        cs_n = 1'b1;
        mosi = ~word[15];
        // gap well above the three core cycles that the link needs between frames
        #120;
    endtask
endmodule

// file: testbench/wake_cdr_config_regs_tb_top.sv
// testbench: register access over the serial link, filter, clock select, clamp and restart
`timescale 1ns/1ns
module wake_cdr_config_regs_tb_top;
    import wake_cdr_pkg::*;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic SPI_CLK, SPI_CS_N, SPI_MOSI, SPI_MISO, SPI_MISO_OE_N;
    logic RESTART = 1'b0;
    logic EDGE_VALID = 1'b0;
    logic MEAS_VALID = 1'b0;
    logic [1:0] WATCHDOG_FAILURE_BITS = 2'h0;
    logic [3:0] EDGE_SPACING = 4'h0;
    logic [7:0] MEAS_LEN = 8'h00;
    logic [7:0] BIT_LENGTH_SETTING = 8'ha0;
    logic CLOCK_RECOVERY_ENABLE, CLAMPED_VALID;
    logic [5:0] FILTER_TIME_CONSTANT;
    logic [1:0] RECOVERY_CLOCK_SEL;
    logic [6:0] RECOVERY_CLOCK_MHZ;
    logic [7:0] CLAMPED_LEN, STATUS_FLAGS;
    logic [15:0] LAST_ANSWER;
    // no pull on the answer line: when released it shows the inverse
    wire miso_line = SPI_MISO_OE_N ? ~SPI_MISO : SPI_MISO;
    int fails = 0;
    int tests_run = 0;
    logic [15:0] prev_answer = 16'h0000;

    always #5 CLOCK = ~CLOCK;

    wake_cdr_config_regs dut (.CLOCK(CLOCK), .RST(RST), .SPI_CLK(SPI_CLK),
        .SPI_CS_N(SPI_CS_N), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO),
        .SPI_MISO_OE_N(SPI_MISO_OE_N), .RESTART(RESTART),
        .WATCHDOG_FAILURE_BITS(WATCHDOG_FAILURE_BITS), .EDGE_VALID(EDGE_VALID),
        .EDGE_SPACING(EDGE_SPACING), .MEAS_VALID(MEAS_VALID), .MEAS_LEN(MEAS_LEN),
        .BIT_LENGTH_SETTING(BIT_LENGTH_SETTING), .CLOCK_RECOVERY_ENABLE(CLOCK_RECOVERY_ENABLE),
        .FILTER_TIME_CONSTANT(FILTER_TIME_CONSTANT), .RECOVERY_CLOCK_SEL(RECOVERY_CLOCK_SEL),
        .RECOVERY_CLOCK_MHZ(RECOVERY_CLOCK_MHZ), .CLAMPED_LEN(CLAMPED_LEN),
        .CLAMPED_VALID(CLAMPED_VALID), .LAST_ANSWER(LAST_ANSWER), .STATUS_FLAGS(STATUS_FLAGS));

    spi_host_model host (.sclk(SPI_CLK), .cs_n(SPI_CS_N), .mosi(SPI_MOSI), .miso(miso_line));

    task automatic results();
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    // old is the register value before this frame; its answer travels in the next frame
    task automatic xfer(input logic [6:0] addr, input logic mode, input logic [7:0] data,
        input logic [7:0] old);
        logic [15:0] got;
        host.frame({data, mode, addr}, got);
        chk(got, prev_answer);
        prev_answer = {old, addr, 1'b0};
        chk(LAST_ANSWER, prev_answer);
    endtask

    // sel 0 drives a measurement, sel 1 an edge spacing; returns once the result has landed
    task automatic pulse(input logic sel, input logic [7:0] val);
        @(posedge CLOCK) #1;
        MEAS_LEN = val;
        EDGE_SPACING = val[3:0];
        MEAS_VALID = ~sel;
        EDGE_VALID = sel;
        @(posedge CLOCK) #1;
        MEAS_VALID = 1'b0;
        EDGE_VALID = 1'b0;
    endtask

    task automatic t_reset();
        chk(FILTER_TIME_CONSTANT, 16'h0010);
        chk(RECOVERY_CLOCK_MHZ, 16'h0050);
        chk(CLOCK_RECOVERY_ENABLE, 16'h0000);
        xfer(ADDR_CONTROL_ONE, 1'b0, 8'h00, 8'h04);
        xfer(ADDR_CLOCK_SELECT, 1'b0, 8'h00, 8'h00);
        xfer(ADDR_UPPER_LIMIT, 1'b0, 8'h00, 8'ha8);
        xfer(ADDR_LOWER_LIMIT, 1'b0, 8'h00, 8'h98);
    endtask

    task automatic t_filter();
        logic [7:0] last = 8'h04;
        logic [5:0] tc [3] = '{6'h08, 6'h10, 6'h20};
        logic [3:0] gap [6] = '{4'h9, 4'h2, 4'ha, 4'h4, 4'h3, 4'h8};
        logic [5:0] gtc [6] = '{6'h08, 6'h20, 6'h08, 6'h10, 6'h20, 6'h10};
        for (int c = 0; c < 4; c++)
        begin
            // reserved bits written as ones must come back as zero
            xfer(ADDR_CONTROL_ONE, 1'b1, {4'hf, c[1:0], 2'h3}, last);
            last = {4'h0, c[1:0], 2'h1};
            chk(CLOCK_RECOVERY_ENABLE, 16'h0001);
            if (c < 3)
                chk(FILTER_TIME_CONSTANT, tc[c]);
        end
        for (int g = 0; g < 6; g++)
        begin
            pulse(1'b1, {4'h0, gap[g]});
            chk(FILTER_TIME_CONSTANT, gtc[g]);
        end
        xfer(ADDR_CONTROL_ONE, 1'b1, 8'h0c, last);
        chk(CLOCK_RECOVERY_ENABLE, 16'h0000);
        xfer(ADDR_CONTROL_ONE, 1'b0, 8'h00, 8'h0c);
    endtask

    task automatic t_clock();
        logic [7:0] last = 8'h00;
        logic [6:0] mhz [4] = '{7'h50, 7'h28, 7'h14, 7'h0a};
        for (int c = 0; c < 4; c++)
        begin
            xfer(ADDR_CLOCK_SELECT, 1'b1, {6'h3f, c[1:0]}, last);
            last = {6'h00, c[1:0]};
            chk(RECOVERY_CLOCK_SEL, c[1:0]);
            @(posedge CLOCK) #1;
            chk(RECOVERY_CLOCK_MHZ, mhz[c]);
        end
    endtask

    task automatic t_clamp();
        logic [7:0] meas [4] = '{8'ha8, 8'ha9, 8'h98, 8'h97};
        logic [7:0] exp [4] = '{8'ha8, 8'ha8, 8'h98, 8'h98};
        xfer(ADDR_CONTROL_ONE, 1'b1, 8'h05, 8'h0c);
        // recommended set for 160 recovery clocks per bit
        // 160 clocks per bit stays below the counter's overflow limit
        xfer(ADDR_UPPER_LIMIT, 1'b1, 8'ha8, 8'ha8);
        xfer(ADDR_LOWER_LIMIT, 1'b1, 8'h98, 8'h98);
        WATCHDOG_FAILURE_BITS = 2'h2;
        for (int m = 0; m < 4; m++)
        begin
            pulse(1'b0, meas[m]);
            chk(CLAMPED_VALID, 16'h0001);
            chk(CLAMPED_LEN, exp[m]);
        end
        chk(STATUS_FLAGS, 16'h001b);
        xfer(ADDR_STATUS, 1'b0, 8'h00, 8'h1b);
        chk(STATUS_FLAGS, 16'h001b);
        xfer(ADDR_STATUS, 1'b1, 8'hff, 8'h1b);
        chk(STATUS_FLAGS, 16'h0018);
        WATCHDOG_FAILURE_BITS = 2'h0;
        repeat (2) @(posedge CLOCK);
        #1;
        chk(STATUS_FLAGS, 16'h0010);
    endtask

    task automatic t_restart();
        // recommended set for 80 recovery clocks per bit
        // 80 clocks per bit keeps well above the imprecise range
        xfer(ADDR_UPPER_LIMIT, 1'b1, 8'h54, 8'ha8);
        xfer(ADDR_LOWER_LIMIT, 1'b1, 8'h4c, 8'h98);
        xfer(7'h10, 1'b1, 8'hff, 8'h00);
        @(posedge CLOCK) #1;
        RESTART = 1'b1;
        @(posedge CLOCK) #1;
        RESTART = 1'b0;
        repeat (2) @(posedge CLOCK);
        #1;
        chk(CLOCK_RECOVERY_ENABLE, 16'h0000);
        chk(RECOVERY_CLOCK_SEL, 16'h0003);
        xfer(7'h10, 1'b0, 8'h00, 8'h00);
        xfer(ADDR_CLOCK_SELECT, 1'b0, 8'h00, 8'h03);
        xfer(ADDR_UPPER_LIMIT, 1'b0, 8'h00, 8'h54);
        xfer(ADDR_LOWER_LIMIT, 1'b0, 8'h00, 8'h4c);
        xfer(ADDR_CONTROL_ONE, 1'b0, 8'h00, 8'h04);
    endtask

    initial
    begin
        repeat (20) @(posedge CLOCK);
        #1;
        RST = 1'b0;
        @(posedge CLOCK) #1;
        t_reset();
        t_filter();
        t_clock();
        t_clamp();
        t_restart();
        results();
    end

    initial
    begin
        #500000;
        fails++;
        results();
    end
endmodule
